// ===== verilog/drive_status_pkg.sv
package drive_status_pkg;

	// ==========================================================
	// widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;
	localparam int FREQ_W = 16;
	localparam int SEL_W = 5;
	localparam int NUM_COND = 18;
	localparam int MASK_W = 3;
	localparam int TRY_W = 8;
	localparam int NUM_OUT = 2;
	localparam int STAT_PAD_W = 6;

	// ==========================================================
	// register offsets (word index on the plain port)
	localparam logic [ADDR_W-1:0] ADDR_TERM_SEL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RELAY_SEL = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_DET_LEVEL = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_DET_BW = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_MAX_FREQ = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_RESTART_TRY = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;

	// ==========================================================
	// reset values; frequencies in units of 0.01 Hz
	localparam logic [SEL_W-1:0] TERM_SEL_RST = 5'h0C;
	localparam logic [SEL_W-1:0] RELAY_SEL_RST = 5'h11;
	localparam logic [MASK_W-1:0] FAULT_MASK_RST = 3'h2;
	localparam logic [FREQ_W-1:0] DET_LEVEL_RST = 16'h0BB8;
	localparam logic [FREQ_W-1:0] DET_BW_RST = 16'h03E8;
	localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1770;
	localparam logic [TRY_W-1:0] RESTART_TRY_RST = 8'h00;
	localparam logic [FREQ_W-1:0] FREQ_LIMIT = 16'h9C40;

	// ==========================================================
	// selection codes, also bit positions in the condition vector
	localparam int COND_AGREE = 0;
	localparam int COND_LEVEL_AGREE = 1;
	localparam int COND_WINDOW = 2;
	localparam int COND_THRESH = 3;
	localparam int COND_THRESH_INV = 4;
	localparam int COND_MOTOR_OL = 5;
	localparam int COND_DRIVE_OL = 6;
	localparam int COND_STALL = 7;
	localparam int COND_OV_TRIP = 8;
	localparam int COND_LV_TRIP = 9;
	localparam int COND_HEATSINK = 10;
	localparam int COND_CMD_LOSS = 11;
	localparam int COND_RUNNING = 12;
	localparam int COND_STOPPED = 13;
	localparam int COND_CONST_RUN = 14;
	localparam int COND_SPEED_SEARCH = 15;
	localparam int COND_WAIT_RUN = 16;
	localparam int COND_FAULT = 17;

	// fault class mask bits
	localparam int MASK_LV_BIT = 0;
	localparam int MASK_OTHER_BIT = 1;
	localparam int MASK_RESTART_BIT = 2;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic motor_overload_warn;
		logic drive_overload_flag;
		logic stall_active;
		logic ov_trip;
		logic lv_trip;
		logic heatsink_overtemp_flag;
		logic other_trip;
		logic cmd_loss;
		logic run_cmd;
		logic volt_out;
		logic stopped;
		logic const_run;
		logic speed_search;
		logic wait_run;
		logic restart_active;
	} drive_status_t;

	typedef struct packed {
		logic [FREQ_W-1:0] cmd_freq;
		logic [FREQ_W-1:0] run_freq;
	} freq_in_t;

endpackage

// ===== verilog/freq_detect.sv
`timescale 1ns/1ns
module freq_detect (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input drive_status_pkg::freq_in_t freq_i,
	input wire logic [drive_status_pkg::FREQ_W-1:0] level_i,
	input wire logic [drive_status_pkg::FREQ_W-1:0] bw_i,
	output logic agree_o,
	output logic level_agree_o,
	output logic window_o,
	output logic threshold_o
);
	import drive_status_pkg::*;

	// ==========================================================
	// comparisons
	wire [FREQ_W-1:0] half_bw = bw_i >> 1;
	wire [FREQ_W-1:0] run = freq_i.run_freq;
	wire [FREQ_W-1:0] cmd = freq_i.cmd_freq;
	wire [FREQ_W-1:0] cmd_diff = (cmd >= run) ? cmd - run : run - cmd;
	wire [FREQ_W-1:0] lvl_diff = (level_i >= run) ? level_i - run : run - level_i;
	wire reached = run >= level_i;
	// lower edge clamps at zero so a wide band never wraps
	wire above_low = (half_bw > level_i) || (run > level_i - half_bw);
	logic thr_r;
	wire thr_nxt = reached || (thr_r && above_low);

	assign agree_o = cmd_diff <= half_bw;
	assign level_agree_o = (cmd == level_i) && agree_o;
	assign window_o = lvl_diff <= half_bw;
	assign threshold_o = thr_r;

	// hysteresis: set on reaching the level, held until falling to level minus half band
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			thr_r <= 1'b0;
		end else begin
			thr_r <= thr_nxt;
		end
	end

	// ==========================================================
	// checks
	sequence s_reach;
		reached;
	endsequence

	sequence s_sag_in_band;
		!reached && above_low;
	endsequence

	a_threshold_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_reach |=> threshold_o) else $error("threshold not set at level");
	a_threshold_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		threshold_o ##0 s_sag_in_band |=> threshold_o) else $error("threshold dropped inside band");
	a_threshold_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!reached && !above_low |=> !threshold_o) else $error("threshold held below band");
	a_agree_band: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cmd == run) |-> agree_o) else $error("equal frequencies not in agreement");

endmodule

// ===== verilog/item_select.sv
`timescale 1ns/1ns
module item_select (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [drive_status_pkg::SEL_W-1:0] sel_i,
	input wire logic [drive_status_pkg::NUM_COND-1:0] cond_i,
	output logic out_o
);
	import drive_status_pkg::*;

	logic out_r;
	// codes past the last condition drive nothing rather than alias another item
	wire sel_valid = sel_i < SEL_W'(NUM_COND);
	wire pick = sel_valid ? cond_i[sel_i] : 1'b0;
	wire out_nxt = pick;

	assign out_o = out_r;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	// ==========================================================
	// checks
	a_select_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		sel_valid |=> out_o == $past(cond_i[sel_i])) else $error("output does not follow selected item");
	a_select_none: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!sel_valid |=> !out_o) else $error("unused code drives output");
	a_select_track: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$stable(sel_i) && sel_valid && $changed(cond_i[sel_i]) |=> $changed(out_o))
		else $error("output not re-evaluated");

endmodule

// ===== verilog/drive_status_output_select.sv
`timescale 1ns/1ns
module drive_status_output_select (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [drive_status_pkg::ADDR_W-1:0] addr_i,
	input wire logic [drive_status_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [drive_status_pkg::DATA_W-1:0] rdata_o,
	input drive_status_pkg::freq_in_t freq_i,
	input drive_status_pkg::drive_status_t status_i,
	output logic transistor_status_output_o,
	output logic status_relay_output_o
);
	import drive_status_pkg::*;

	// ==========================================================
	// settings
	logic [SEL_W-1:0] term_sel_r;
	logic [SEL_W-1:0] relay_sel_r;
	logic [MASK_W-1:0] mask_r;
	logic [FREQ_W-1:0] level_r;
	logic [FREQ_W-1:0] bw_r;
	logic [FREQ_W-1:0] max_freq_r;
	logic [TRY_W-1:0] try_count_r;
	logic [DATA_W-1:0] rdata_r;

	// ==========================================================
	// write decode
	wire wr_term = wr_i && (addr_i == ADDR_TERM_SEL);
	wire wr_relay = wr_i && (addr_i == ADDR_RELAY_SEL);
	wire wr_mask = wr_i && (addr_i == ADDR_FAULT_MASK);
	wire wr_level = wr_i && (addr_i == ADDR_DET_LEVEL);
	wire wr_bw = wr_i && (addr_i == ADDR_DET_BW);
	wire wr_max = wr_i && (addr_i == ADDR_MAX_FREQ);
	wire wr_try = wr_i && (addr_i == ADDR_RESTART_TRY);
	wire [FREQ_W-1:0] wfreq = wdata_i[FREQ_W-1:0];
	wire upper_clear = (wdata_i[DATA_W-1:FREQ_W] == '0);
	// an out-of-range setting is dropped and the old value kept, as the keypad refuses it
	wire in_range = upper_clear && (wfreq <= FREQ_LIMIT);
	wire freq_ok = in_range && (wfreq <= max_freq_r);
	wire level_take = wr_level && freq_ok;
	wire bw_take = wr_bw && freq_ok;
	wire max_take = wr_max && in_range;

	wire [SEL_W-1:0] term_sel_nxt = wr_term ? wdata_i[SEL_W-1:0] : term_sel_r;
	wire [SEL_W-1:0] relay_sel_nxt = wr_relay ? wdata_i[SEL_W-1:0] : relay_sel_r;
	wire [MASK_W-1:0] mask_nxt = wr_mask ? wdata_i[MASK_W-1:0] : mask_r;
	wire [FREQ_W-1:0] level_nxt = level_take ? wfreq : level_r;
	wire [FREQ_W-1:0] bw_nxt = bw_take ? wfreq : bw_r;
	wire [FREQ_W-1:0] max_freq_nxt = max_take ? wfreq : max_freq_r;
	wire [TRY_W-1:0] try_count_nxt = wr_try ? wdata_i[TRY_W-1:0] : try_count_r;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			term_sel_r <= TERM_SEL_RST;
			relay_sel_r <= RELAY_SEL_RST;
			mask_r <= FAULT_MASK_RST;
			level_r <= DET_LEVEL_RST;
			bw_r <= DET_BW_RST;
			max_freq_r <= MAX_FREQ_RST;
			try_count_r <= RESTART_TRY_RST;
		end else begin
			term_sel_r <= term_sel_nxt;
			relay_sel_r <= relay_sel_nxt;
			mask_r <= mask_nxt;
			level_r <= level_nxt;
			bw_r <= bw_nxt;
			max_freq_r <= max_freq_nxt;
			try_count_r <= try_count_nxt;
		end
	end

	// ==========================================================
	// frequency detection
	logic agree;
	logic level_agree;
	logic window;
	logic threshold;

	freq_detect u_freq_detect (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.freq_i(freq_i),
		.level_i(level_r),
		.bw_i(bw_r),
		.agree_o(agree),
		.level_agree_o(level_agree),
		.window_o(window),
		.threshold_o(threshold)
	);

	// ==========================================================
	// fault class
	wire non_lv_trip = status_i.ov_trip || status_i.heatsink_overtemp_flag || status_i.other_trip;
	// restart signalling only counts once retries are configured at all
	wire restart_armed = status_i.restart_active && (try_count_r != '0);
	wire fault_lv = mask_r[MASK_LV_BIT] && status_i.lv_trip;
	wire fault_other = mask_r[MASK_OTHER_BIT] && non_lv_trip;
	wire fault_restart = mask_r[MASK_RESTART_BIT] && restart_armed;
	wire fault_active = fault_lv || fault_other || fault_restart;

	// ==========================================================
	// condition vector, indexed by selection code
	wire [NUM_COND-1:0] cond;

	assign cond[COND_AGREE] = agree;
	assign cond[COND_LEVEL_AGREE] = level_agree;
	assign cond[COND_WINDOW] = window;
	assign cond[COND_THRESH] = threshold;
	assign cond[COND_THRESH_INV] = !threshold;
	assign cond[COND_MOTOR_OL] = status_i.motor_overload_warn;
	assign cond[COND_DRIVE_OL] = status_i.drive_overload_flag;
	assign cond[COND_STALL] = status_i.stall_active;
	assign cond[COND_OV_TRIP] = status_i.ov_trip;
	assign cond[COND_LV_TRIP] = status_i.lv_trip;
	assign cond[COND_HEATSINK] = status_i.heatsink_overtemp_flag;
	assign cond[COND_CMD_LOSS] = status_i.cmd_loss;
	assign cond[COND_RUNNING] = status_i.run_cmd && status_i.volt_out;
	assign cond[COND_STOPPED] = status_i.stopped;
	assign cond[COND_CONST_RUN] = status_i.const_run;
	assign cond[COND_SPEED_SEARCH] = status_i.speed_search;
	assign cond[COND_WAIT_RUN] = status_i.wait_run;
	assign cond[COND_FAULT] = fault_active;

	// ==========================================================
	// output selectors: index 0 terminal, index 1 relay
	wire [SEL_W-1:0] sel_vec [NUM_OUT];
	wire [NUM_OUT-1:0] outs;

	assign sel_vec[0] = term_sel_r;
	assign sel_vec[1] = relay_sel_r;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			item_select u_item_select (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.sel_i(sel_vec[gi]),
				.cond_i(cond),
				.out_o(outs[gi])
			);
		end
	endgenerate

	assign transistor_status_output_o = outs[0];
	assign status_relay_output_o = outs[1];

	// ==========================================================
	// read path: data stands only in the cycle after the strobe
	wire [DATA_W-1:0] status_word = DATA_W'({outs[1], outs[0], {STAT_PAD_W{1'b0}}, cond});
	wire [DATA_W-1:0] rd_mux =
		(addr_i == ADDR_TERM_SEL) ? DATA_W'(term_sel_r) :
		(addr_i == ADDR_RELAY_SEL) ? DATA_W'(relay_sel_r) :
		(addr_i == ADDR_FAULT_MASK) ? DATA_W'(mask_r) :
		(addr_i == ADDR_DET_LEVEL) ? DATA_W'(level_r) :
		(addr_i == ADDR_DET_BW) ? DATA_W'(bw_r) :
		(addr_i == ADDR_MAX_FREQ) ? DATA_W'(max_freq_r) :
		(addr_i == ADDR_RESTART_TRY) ? DATA_W'(try_count_r) :
		(addr_i == ADDR_STATUS) ? status_word : '0;
	wire [DATA_W-1:0] rdata_nxt = rd_i ? rd_mux : '0;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;

	// ==========================================================
	// checks
	a_level_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && (addr_i == ADDR_DET_LEVEL) && (wdata_i > DATA_W'(max_freq_r)) |=> $stable(level_r))
		else $error("level accepted above max frequency");

	a_bw_accept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && (addr_i == ADDR_DET_BW) && (wdata_i <= DATA_W'(max_freq_r)) && (wdata_i <= DATA_W'(FREQ_LIMIT))
		|=> bw_r == $past(wdata_i[FREQ_W-1:0])) else $error("valid bandwidth not stored");

	a_bw_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && (addr_i == ADDR_DET_BW) && (wdata_i > DATA_W'(FREQ_LIMIT)) |=> $stable(bw_r))
		else $error("bandwidth accepted above limit");

	a_fault_mask_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_FAULT)) && (mask_r == 3'h2) && status_i.lv_trip && !non_lv_trip
		|=> !transistor_status_output_o) else $error("undervoltage signalled with mask 2");

	a_fault_other: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(relay_sel_r == SEL_W'(COND_FAULT)) && mask_r[MASK_OTHER_BIT] && non_lv_trip
		|=> status_relay_output_o) else $error("trip not signalled on relay");

	a_overvolt_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_OV_TRIP)) && status_i.ov_trip |=> transistor_status_output_o)
		else $error("overvoltage trip not on terminal");

	a_cmd_loss_relay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(relay_sel_r == SEL_W'(COND_CMD_LOSS)) && status_i.cmd_loss |=> status_relay_output_o)
		else $error("command loss not on relay");

	a_running_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(relay_sel_r == SEL_W'(COND_RUNNING)) && !(status_i.run_cmd && status_i.volt_out)
		|=> !status_relay_output_o) else $error("running asserted without run and voltage");

	a_read_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rd_i && (addr_i == ADDR_FAULT_MASK) |=> (rdata_o == DATA_W'(mask_r)) ##1 (rdata_o == '0 || $past(rd_i)))
		else $error("read data timing wrong");

	a_level_accept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && (addr_i == ADDR_DET_LEVEL) && (wdata_i <= DATA_W'(max_freq_r)) && (wdata_i <= DATA_W'(FREQ_LIMIT))
		|=> level_r == $past(wdata_i[FREQ_W-1:0])) else $error("valid level not stored");

	a_max_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wr_i && (addr_i == ADDR_MAX_FREQ) && (wdata_i > DATA_W'(FREQ_LIMIT)) |=> $stable(max_freq_r))
		else $error("max frequency accepted above limit");

	a_term_fault_lv: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_FAULT)) && mask_r[MASK_LV_BIT] && status_i.lv_trip |=> transistor_status_output_o)
		else $error("undervoltage trip not signalled on terminal");

	a_relay_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(relay_sel_r == SEL_W'(COND_FAULT)) && mask_r[MASK_RESTART_BIT] && status_i.restart_active
		&& (try_count_r != '0) |=> status_relay_output_o) else $error("restart attempt not signalled on relay");

	a_relay_fault_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(relay_sel_r == SEL_W'(COND_FAULT)) && !status_i.lv_trip && !non_lv_trip && !status_i.restart_active
		|=> !status_relay_output_o) else $error("fault output without any trip");

	a_search_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_SPEED_SEARCH)) && status_i.speed_search |=> transistor_status_output_o)
		else $error("speed search not on terminal");

	a_wait_run_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_WAIT_RUN)) && status_i.wait_run |=> transistor_status_output_o)
		else $error("wait for run not on terminal");

	a_agree_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_AGREE)) && (freq_i.cmd_freq == freq_i.run_freq) |=> transistor_status_output_o)
		else $error("equal frequencies not shown as agreement");

	a_level_agree_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_LEVEL_AGREE)) && (freq_i.cmd_freq != level_r) |=> !transistor_status_output_o)
		else $error("level agreement without command at level");

	a_window_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_WINDOW)) && (freq_i.run_freq == level_r) |=> transistor_status_output_o)
		else $error("running frequency at level not in window");

	a_thresh_inverse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_THRESH)) && (relay_sel_r == SEL_W'(COND_THRESH_INV))
		|=> transistor_status_output_o != status_relay_output_o) else $error("inverse threshold not inverted");

	a_motor_ol_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_MOTOR_OL)) && status_i.motor_overload_warn |=> transistor_status_output_o)
		else $error("motor overload not on terminal");

	a_drive_ol_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_DRIVE_OL)) && status_i.drive_overload_flag |=> transistor_status_output_o)
		else $error("drive overload not on terminal");

	a_stall_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_STALL)) && status_i.stall_active |=> transistor_status_output_o)
		else $error("stall prevention not on terminal");

	a_lowvolt_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_LV_TRIP)) && status_i.lv_trip |=> transistor_status_output_o)
		else $error("undervoltage trip not on terminal");

	a_heatsink_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_HEATSINK)) && status_i.heatsink_overtemp_flag |=> transistor_status_output_o)
		else $error("heatsink protection not on terminal");

	a_running_term: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(term_sel_r == SEL_W'(COND_RUNNING)) && status_i.run_cmd && status_i.volt_out |=> transistor_status_output_o)
		else $error("running not on terminal");

	a_read_unmapped: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rd_i && (addr_i > ADDR_STATUS) |=> rdata_o == '0)
		else $error("unmapped read returned data");

	a_read_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!rd_i |=> rdata_o == '0)
		else $error("read data shown without a read");

endmodule

// ===== test/status_reader.sv
`timescale 1ns/1ns
module status_reader (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic term_i,
	input wire logic relay_i,
	output logic term_seen_o,
	output logic relay_seen_o
);
	// ==========================================================
	// external sequence
	// the far side samples the contacts on its own edge, so what it sees trails the pins by one cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			term_seen_o <= 1'b0;
			relay_seen_o <= 1'b0;
		end else begin
			term_seen_o <= term_i;
			relay_seen_o <= relay_i;
		end
	end
endmodule

// ===== test/test_drive_status_output_select.sv
`timescale 1ns/1ns
module test_drive_status_output_select;
	import drive_status_pkg::*;

	logic clk_i;
	logic sys_rst_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [DATA_W-1:0] rdata_o;
	freq_in_t fq;
	drive_status_t st;
	drive_status_t s;
	logic fexp;
	logic term_o;
	logic relay_o;
	logic term_seen;
	logic relay_seen;
	int miscompares;
	int num_checks;

	drive_status_output_select drive_status_output_select_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .freq_i(fq), .status_i(st), .transistor_status_output_o(term_o),
		.status_relay_output_o(relay_o)
	);

	status_reader status_reader_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .term_i(term_o), .relay_i(relay_o),
		.term_seen_o(term_seen), .relay_seen_o(relay_seen)
	);

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	// long enough for the two-flop threshold path plus the reader's own flop
	task automatic outs(input logic t_exp, input logic r_exp);
		repeat (4) @(posedge clk_i);
		#1;
		chk({30'h0, term_o, relay_o}, {30'h0, t_exp, r_exp});
		chk({30'h0, term_seen, relay_seen}, {30'h0, t_exp, r_exp});
	endtask

	task automatic fcase(input logic [15:0] cmd, input logic [15:0] run, input logic t_exp, input logic r_exp);
		fq <= '{cmd_freq: cmd, run_freq: run};
		outs(t_exp, r_exp);
	endtask

	function automatic drive_status_t cond_of(input int c);
		drive_status_t r;
		r = '0;
		case (c)
			5: r.motor_overload_warn = 1'b1;
			6: r.drive_overload_flag = 1'b1;
			7: r.stall_active = 1'b1;
			8: r.ov_trip = 1'b1;
			9: r.lv_trip = 1'b1;
			10: r.heatsink_overtemp_flag = 1'b1;
			11: r.cmd_loss = 1'b1;
			12: begin
				r.run_cmd = 1'b1;
				r.volt_out = 1'b1;
			end
			13: r.stopped = 1'b1;
			14: r.const_run = 1'b1;
			15: r.speed_search = 1'b1;
			default: r.wait_run = 1'b1;
		endcase
		return r;
	endfunction

	// ==========================================================
	// clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		finish_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		sys_rst_i = 1'b1;
		addr_i = '0;
		wdata_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		fq = '0;
		st = '0;
		miscompares = 0;
		num_checks = 0;
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// reset values and the register map
		rd(ADDR_TERM_SEL, 32'(TERM_SEL_RST));
		rd(ADDR_RELAY_SEL, 32'(RELAY_SEL_RST));
		rd(ADDR_FAULT_MASK, 32'(FAULT_MASK_RST));
		rd(ADDR_DET_LEVEL, 32'(DET_LEVEL_RST));
		rd(ADDR_DET_BW, 32'(DET_BW_RST));
		rd(ADDR_MAX_FREQ, 32'(MAX_FREQ_RST));
		rd(ADDR_RESTART_TRY, 32'(RESTART_TRY_RST));
		rd(4'h8, 32'h0);
		// settings above the maximum frequency are refused, at the maximum accepted
		wr(ADDR_DET_LEVEL, 32'h0000_1771);
		rd(ADDR_DET_LEVEL, 32'(DET_LEVEL_RST));
		wr(ADDR_DET_BW, 32'h0000_1771);
		rd(ADDR_DET_BW, 32'(DET_BW_RST));
		wr(ADDR_DET_BW, 32'h0000_1770);
		rd(ADDR_DET_BW, 32'h0000_1770);
		wr(ADDR_DET_BW, 32'(DET_BW_RST));
		wr(ADDR_DET_BW, 32'h0000_9C41);
		rd(ADDR_DET_BW, 32'(DET_BW_RST));
		wr(ADDR_MAX_FREQ, 32'h0000_9C41);
		rd(ADDR_MAX_FREQ, 32'(MAX_FREQ_RST));
		wr(ADDR_DET_LEVEL, 32'h0001_0BB8);
		rd(ADDR_DET_LEVEL, 32'(DET_LEVEL_RST));
		wr(ADDR_DET_LEVEL, 32'h0000_07D0);
		rd(ADDR_DET_LEVEL, 32'h0000_07D0);
		wr(ADDR_DET_LEVEL, 32'(DET_LEVEL_RST));
		// plain status items, relay on the next code to show the two selections stay apart
		for (int c = 5; c <= 16; c++) begin
			wr(ADDR_TERM_SEL, 32'(c));
			wr(ADDR_RELAY_SEL, 32'(c + 1));
			st <= cond_of(c);
			outs(1'b1, 1'b0);
			st <= '0;
			outs(1'b0, 1'b0);
		end
		wr(ADDR_RELAY_SEL, 32'h0000_000B);
		st <= cond_of(11);
		outs(1'b0, 1'b1);
		s = '0;
		s.run_cmd = 1'b1;
		wr(ADDR_TERM_SEL, 32'h0000_000C);
		st <= s;
		outs(1'b0, 1'b0);
		st <= '1;
		wr(ADDR_TERM_SEL, 32'h0000_001F);
		outs(1'b0, 1'b1);
		st <= '0;
		// frequency detection with level 30.00 Hz and bandwidth 10.00 Hz
		wr(ADDR_TERM_SEL, 32'h0000_0000);
		fcase(16'h07D0, 16'h05DC, 1'b1, 1'b0);
		fcase(16'h07D0, 16'h05DB, 1'b0, 1'b0);
		wr(ADDR_TERM_SEL, 32'h0000_0001);
		fcase(16'h0BB8, 16'h0BB8, 1'b1, 1'b0);
		fcase(16'h0BB7, 16'h0BB7, 1'b0, 1'b0);
		wr(ADDR_TERM_SEL, 32'h0000_0002);
		fcase(16'h0000, 16'h09C4, 1'b1, 1'b0);
		fcase(16'h0000, 16'h09C3, 1'b0, 1'b0);
		fcase(16'h0000, 16'h0DAC, 1'b1, 1'b0);
		fcase(16'h0000, 16'h0DAD, 1'b0, 1'b0);
		wr(ADDR_TERM_SEL, 32'h0000_0003);
		wr(ADDR_RELAY_SEL, 32'h0000_0004);
		fcase(16'h0000, 16'h0000, 1'b0, 1'b1);
		fcase(16'h0000, 16'h0BB7, 1'b0, 1'b1);
		fcase(16'h0000, 16'h0BB8, 1'b1, 1'b0);
		fcase(16'h0000, 16'h09C5, 1'b1, 1'b0);
		fcase(16'h0000, 16'h09C4, 1'b0, 1'b1);
		fcase(16'h0000, 16'h0BB7, 1'b0, 1'b1);
		fq <= '0;
		// fault output under every mask value, one trip class at a time
		wr(ADDR_TERM_SEL, 32'h0000_0011);
		wr(ADDR_RELAY_SEL, 32'h0000_0011);
		wr(ADDR_RESTART_TRY, 32'h0000_0001);
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_FAULT_MASK, 32'(m));
			rd(ADDR_FAULT_MASK, 32'(m));
			for (int k = 0; k < 5; k++) begin
				s = '0;
				if (k == 0) s.lv_trip = 1'b1;
				if (k == 1) s.ov_trip = 1'b1;
				if (k == 2) s.restart_active = 1'b1;
				if (k == 3) s.heatsink_overtemp_flag = 1'b1;
				if (k == 4) s.other_trip = 1'b1;
				fexp = (k == 0) ? m[0] : (k == 2) ? m[2] : m[1];
				st <= s;
				outs(fexp, fexp);
				st <= '0;
				outs(1'b0, 1'b0);
			end
		end
		// restart attempts only count while a try count is set
		wr(ADDR_RESTART_TRY, 32'h0000_0000);
		s = '0;
		s.restart_active = 1'b1;
		st <= s;
		outs(1'b0, 1'b0);
		st <= cond_of(8);
		outs(1'b1, 1'b1);
		rd(ADDR_STATUS, 32'h0302_0111);
		// reset again in mid-run: settings back to defaults, outputs follow one clock after release
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(ADDR_TERM_SEL, 32'(TERM_SEL_RST));
		outs(1'b0, 1'b1);
		finish_test();
	end
endmodule
